// ===== rtl/fiber_to_copper_symbol_path.sv
`timescale 1ns/1ps
module fiber_to_copper_symbol_path
  import symbol_path_pkg::*;
#(
  parameter int FLASH_LEN = FLASH_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Configuration straps
  input wire logic force_fiber_signal_detect_i,
  input wire logic test_port_enable_i,
  input wire logic test_port_side_select_i,
  input wire logic scrambler_bypass_i,
  // Fiber receive side
  input wire logic fiber_rx_nrzi_i,
  input wire logic fiber_signal_detect_i,
  // Copper transmit side
  output logic tx_nrzi_o,
  output symbol_path_pkg::mlt3_t tx_mlt3_o,
  // Indicator
  output logic fiber_error_indicator_n_o,
  // Test port
  input wire logic [symbol_path_pkg::TPI_W-1:0] test_port_in_i,
  output logic [symbol_path_pkg::TPO_W-1:0] test_port_out_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [symbol_path_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt
  output logic irq_o
);

  import symbol_path_pkg::*;

  localparam int PIN_W = 6 + TPI_W;
  localparam int DIV_W = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);
  localparam logic [2:0] SLOT_LAST = 3'(SYM_BITS - 1);
  localparam logic [FLASH_W-1:0] FLASH_LOAD = FLASH_W'(FLASH_LEN);

  // Pin synchronisers; no reset, so strap levels reach the capture during reset
  logic [PIN_W-1:0] pin_meta_r;
  logic [PIN_W-1:0] pin_sync_r;
  logic rx_pin;
  logic sd_pin;
  logic [TPI_W-1:0] tpi_pin;
  strap_t strap_pin;
  strap_t strap_r;

  always_ff @(posedge sys_clk_i) begin
    pin_meta_r <= {test_port_in_i, fiber_signal_detect_i, fiber_rx_nrzi_i,
                   force_fiber_signal_detect_i, test_port_enable_i,
                   test_port_side_select_i, scrambler_bypass_i};
    pin_sync_r <= pin_meta_r;
  end

  assign strap_pin = pin_sync_r[3:0];
  assign rx_pin = pin_sync_r[4];
  assign sd_pin = pin_sync_r[5];
  assign tpi_pin = pin_sync_r[PIN_W-1:6];

  // Straps follow the pins only while reset is held, then freeze
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_r <= strap_pin;
    end
  end

  // Test port qualification
  logic tp_fiber;
  logic tp_copper;
  assign tp_fiber = strap_r.test_port_enable && strap_r.test_port_side_select;
  assign tp_copper = strap_r.test_port_enable && !strap_r.test_port_side_select;

  // Bit-rate enable
  logic [DIV_W-1:0] div_r;
  logic bit_en;

  assign bit_en = (div_r == DIV_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || bit_en) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  // Signal detect and link
  logic sd_eff;
  logic link_r;

  // Unless the force strap holds detect, fiber-side test input 0 fakes a loss of signal
  assign sd_eff = strap_r.force_fiber_signal_detect ||
                  (sd_pin && !(tp_fiber && tpi_pin[0]));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      link_r <= 1'b0;
    end else begin
      link_r <= sd_eff;
    end
  end

  // NRZI decode and deserializer
  logic rx_prev_r;
  logic rx_nrz;
  logic [2*SYM_BITS-1:0] rx_sh_r;
  logic [2*SYM_BITS-1:0] rx_sh_nxt;
  logic [2:0] slot_r;
  logic aligned_r;
  logic jk_hit;
  logic sym_stb;
  logic [SYM_BITS-1:0] rx_sym;

  assign rx_nrz = rx_pin ^ rx_prev_r;
  assign rx_sh_nxt = {rx_sh_r[2*SYM_BITS-2:0], rx_nrz};
  assign rx_sym = rx_sh_nxt[SYM_BITS-1:0];
  assign jk_hit = bit_en && !aligned_r && link_r && (rx_sh_nxt == {SYM_J, SYM_K});
  assign sym_stb = bit_en && (jk_hit || slot_r == SLOT_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_prev_r <= 1'b0;
      rx_sh_r <= '0;
    end else if (bit_en) begin
      rx_prev_r <= rx_pin;
      rx_sh_r <= rx_sh_nxt;
    end
  end

  // Slot counter free-runs so copper always gets symbols; J/K restarts it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || sym_stb) begin
      slot_r <= 3'h0;
    end else if (bit_en) begin
      slot_r <= slot_r + 3'h1;
    end
  end

  // Boundary holds until Idle or link loss, then search resumes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !link_r) begin
      aligned_r <= 1'b0;
    end else if (jk_hit) begin
      aligned_r <= 1'b1;
    end else if (sym_stb && aligned_r && rx_sym == SYM_IDLE) begin
      aligned_r <= 1'b0;
    end
  end

  // Code-group check
  logic code_err;
  assign code_err = sym_stb && aligned_r && !valid_code(rx_sym);

  // Transmit symbol choice
  logic [CTRL_W-1:0] ctrl_r;
  logic halt_sel;
  logic [SYM_BITS-1:0] plain_sym;
  logic [SYM_BITS-1:0] key_word;
  logic [SYM_BITS-1:0] tx_word;
  logic [SYM_BITS-1:0] tx_sym_r;
  logic [SYM_BITS-1:0] last_rx_r;

  assign halt_sel = ctrl_r[CTRL_HALT] || (tp_copper && tpi_pin[1]);

  always_comb begin
    if (!link_r || (tp_copper && tpi_pin[0])) begin
      plain_sym = halt_sel ? SYM_HALT : SYM_IDLE;
    end else begin
      plain_sym = rx_sym;
    end
  end

  assign tx_word = strap_r.scrambler_bypass ? plain_sym : (plain_sym ^ key_word);

  key_stream #(
    .LEN(KEY_LEN),
    .TAP(KEY_TAP)
  ) u_key (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .bit_en_i(bit_en),
    .key_word_o(key_word)
  );

  // Serializer, MSB first
  logic [SYM_BITS-1:0] ser_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ser_r <= '0;
      tx_sym_r <= '0;
      last_rx_r <= '0;
    end else if (sym_stb) begin
      ser_r <= tx_word;
      tx_sym_r <= tx_word;
      last_rx_r <= rx_sym;
    end else if (bit_en) begin
      ser_r <= {ser_r[SYM_BITS-2:0], 1'b0};
    end
  end

  mlt3_splitter u_mlt3 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .bit_en_i(bit_en),
    .nrz_i(ser_r[SYM_BITS-1]),
    .nrzi_o(tx_nrzi_o),
    .mlt3_o(tx_mlt3_o)
  );

  // Error indicator one-shot
  logic [FLASH_W-1:0] flash_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flash_r <= '0;
    end else if (code_err) begin
      flash_r <= FLASH_LOAD;
    end else if (flash_r != '0) begin
      flash_r <= flash_r - FLASH_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fiber_error_indicator_n_o <= 1'b1;
    end else begin
      fiber_error_indicator_n_o <= !(code_err || flash_r != '0);
    end
  end

  // Test port outputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !strap_r.test_port_enable) begin
      test_port_out_o <= '0;
    end else if (strap_r.test_port_side_select) begin
      test_port_out_o <= {aligned_r, link_r, last_rx_r};
    end else begin
      test_port_out_o <= {halt_sel, tx_sym_r, ser_r[SYM_BITS-1]};
    end
  end

  // Events
  logic link_d_r;
  logic [EV_W-1:0] events;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      link_d_r <= 1'b0;
    end else begin
      link_d_r <= link_r;
    end
  end

  always_comb begin
    events = '0;
    events[EV_CODE_ERR] = code_err;
    events[EV_ALIGNED] = jk_hit;
    events[EV_SD_LOST] = link_d_r && !link_r;
    events[EV_LINK_UP] = link_r && !link_d_r;
  end

  // APB slave, zero wait states
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;
  logic [ERR_CNT_W-1:0] err_cnt_r;

  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign rd = acc && !pwrite_i;
  assign mapped = (paddr_i == OFS_STATUS) || (paddr_i == OFS_MASK) ||
                  (paddr_i == OFS_CTRL) || (paddr_i == OFS_STRAPS) ||
                  (paddr_i == OFS_ERR_COUNT);
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;

  always_comb begin
    prdata_o = '0;
    if (rd) begin
      case (paddr_i)
        OFS_STATUS: prdata_o[EV_W-1:0] = status_r;
        OFS_MASK: prdata_o[EV_W-1:0] = mask_r;
        OFS_CTRL: prdata_o[CTRL_W-1:0] = ctrl_r;
        OFS_STRAPS: prdata_o[3:0] = strap_r;
        OFS_ERR_COUNT: prdata_o[ERR_CNT_W-1:0] = err_cnt_r;
        default: prdata_o = '0;
      endcase
    end
  end

  // Write one to clear; a same-cycle event still sets
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_r <= '0;
    end else if (wr && paddr_i == OFS_STATUS) begin
      status_r <= (status_r & ~pwdata_i[EV_W-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mask_r <= MASK_RESET;
    end else if (wr && paddr_i == OFS_MASK) begin
      mask_r <= pwdata_i[EV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr && paddr_i == OFS_CTRL) begin
      ctrl_r <= pwdata_i[CTRL_W-1:0];
    end
  end

  // Clear on read; an error in the read cycle is kept as a count of one
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      err_cnt_r <= '0;
    end else if (rd && paddr_i == OFS_ERR_COUNT) begin
      err_cnt_r <= ERR_CNT_W'(code_err);
    end else if (code_err && err_cnt_r != '1) begin
      err_cnt_r <= err_cnt_r + ERR_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_r & mask_r);
    end
  end

endmodule

// ===== rtl/symbol_path_pkg.sv
package symbol_path_pkg;

  // Clocking: one system clock, bit rate by enable pulse
  localparam int SYS_CLK_MHZ = 250;
  localparam int BIT_RATE_MHZ = 125;
  localparam int BIT_DIV = SYS_CLK_MHZ / BIT_RATE_MHZ;

  // Symbol and key stream geometry
  localparam int SYM_BITS = 5;
  localparam int KEY_LEN = 11;
  localparam int KEY_TAP = 8;
  localparam logic [KEY_LEN-1:0] KEY_SEED = 11'h7FF;

  // Line symbols
  localparam logic [SYM_BITS-1:0] SYM_IDLE = 5'h1F;
  localparam logic [SYM_BITS-1:0] SYM_J = 5'h18;
  localparam logic [SYM_BITS-1:0] SYM_K = 5'h11;
  localparam logic [SYM_BITS-1:0] SYM_HALT = 5'h04;

  // Error indicator flash time
  localparam int FLASH_TIME_MS = 20;
  localparam int FLASH_CYCLES = FLASH_TIME_MS * 1000 * SYS_CLK_MHZ;
  localparam int FLASH_W = 24;

  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STRAPS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ERR_COUNT = 8'h10;

  // Status / mask bit positions
  localparam int EV_W = 4;
  localparam int EV_CODE_ERR = 0;
  localparam int EV_ALIGNED = 1;
  localparam int EV_SD_LOST = 2;
  localparam int EV_LINK_UP = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

  // Control bits
  localparam int CTRL_W = 1;
  localparam int CTRL_HALT = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 1'h0;

  localparam int ERR_CNT_W = 16;
  localparam int TPI_W = 4;
  localparam int TPO_W = 7;

  typedef struct packed {
    logic force_fiber_signal_detect;
    logic test_port_enable;
    logic test_port_side_select;
    logic scrambler_bypass;
  } strap_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } mlt3_t;

  function automatic logic valid_code(input logic [SYM_BITS-1:0] s);
    case (s)
      5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D,
      5'h1F, 5'h18, 5'h11, 5'h0D, 5'h07, 5'h04: valid_code = 1'b1;
      default: valid_code = 1'b0;
    endcase
  endfunction

endpackage

// ===== rtl/key_stream.sv
`timescale 1ns/1ps
module key_stream
  import symbol_path_pkg::*;
#(
  parameter int LEN = KEY_LEN,
  parameter int TAP = KEY_TAP
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Bit pacing
  input wire logic bit_en_i,
  // Last five key bits, oldest in the top bit
  output logic [SYM_BITS-1:0] key_word_o
);

  logic [LEN-1:0] lfsr_r;
  logic fb;

  assign fb = lfsr_r[LEN-1] ^ lfsr_r[TAP];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lfsr_r <= KEY_SEED;
      key_word_o <= '0;
    end else if (bit_en_i) begin
      lfsr_r <= {lfsr_r[LEN-2:0], fb};
      key_word_o <= {key_word_o[SYM_BITS-2:0], fb};
    end
  end

endmodule

// ===== rtl/mlt3_splitter.sv
`timescale 1ns/1ps
module mlt3_splitter
  import symbol_path_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Serial NRZ in
  input wire logic bit_en_i,
  input wire logic nrz_i,
  // Line side
  output logic nrzi_o,
  output symbol_path_pkg::mlt3_t mlt3_o
);

  logic [1:0] phase_r;
  logic [1:0] phase_nxt;

  assign phase_nxt = phase_r + 2'h1;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nrzi_o <= 1'b0;
    end else if (bit_en_i && nrz_i) begin
      nrzi_o <= ~nrzi_o;
    end
  end

  // Phases 0,+,0,- so every second one lands on a stream, alternately pos and neg
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase_r <= 2'h0;
      mlt3_o <= '0;
    end else if (bit_en_i && nrz_i) begin
      phase_r <= phase_nxt;
      mlt3_o.pos <= (phase_nxt == 2'h1);
      mlt3_o.neg <= (phase_nxt == 2'h3);
    end
  end

endmodule

// ===== test/fiber_source.sv
`timescale 1ns/1ps
module fiber_source
  import symbol_path_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Next symbol, taken while load_o is high
  input wire logic [symbol_path_pkg::SYM_BITS-1:0] sym_i,
  // Fiber line
  output logic nrzi_o,
  output logic load_o
);
  logic [3:0] ph_r;
  logic [SYM_BITS-1:0] sh_r;
  // Fiber never goes quiet: a symbol follows every 10 clocks
  assign load_o = (ph_r == 4'h8);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ph_r <= 4'h0;
      sh_r <= SYM_IDLE;
      nrzi_o <= 1'b0;
    end else begin
      ph_r <= (ph_r == 4'h9) ? 4'h0 : ph_r + 4'h1;
      if (!ph_r[0]) begin
        nrzi_o <= nrzi_o ^ sh_r[SYM_BITS-1];
        sh_r <= load_o ? sym_i : {sh_r[SYM_BITS-2:0], 1'b0};
      end
    end
  end
endmodule

// ===== test/symbol_path_asserts.sv
`timescale 1ns/1ps
module symbol_path_asserts
  import symbol_path_pkg::*;
#(
  parameter int FLASH_LEN = FLASH_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic test_port_enable_i,
  input wire logic tx_nrzi_o,
  input wire symbol_path_pkg::mlt3_t tx_mlt3_o,
  input wire logic fiber_error_indicator_n_o,
  input wire logic [symbol_path_pkg::TPO_W-1:0] test_port_out_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [symbol_path_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  logic tp_en_r;
  logic last_pos_r;
  logic [31:0] low_cnt_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tp_en_r <= test_port_enable_i;
    end
  end
  // First one event after reset goes to the positive rail
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      last_pos_r <= 1'b0;
    end else if ($rose(tx_mlt3_o.pos)) begin
      last_pos_r <= 1'b1;
    end else if ($rose(tx_mlt3_o.neg)) begin
      last_pos_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    low_cnt_r <= fiber_error_indicator_n_o ? 32'h0 : low_cnt_r + 32'h1;
  end
  property p_rail_excl;
    !(tx_mlt3_o.pos && tx_mlt3_o.neg);
  endproperty
  a_rail_excl: assert property (p_rail_excl)
    else $error("both line rails high");
  property p_rail_alt;
    ($rose(tx_mlt3_o.pos) || $rose(tx_mlt3_o.neg)) |-> ($rose(tx_mlt3_o.pos) != last_pos_r);
  endproperty
  a_rail_alt: assert property (p_rail_alt)
    else $error("line rail used twice in a row");
  property p_rail_follow;
    $changed(tx_nrzi_o) |-> ##[0:1] $changed(tx_mlt3_o);
  endproperty
  a_rail_follow: assert property (p_rail_follow)
    else $error("line level did not step with the serial stream");
  property p_bit_rate;
    $changed(tx_nrzi_o) |=> $stable(tx_nrzi_o);
  endproperty
  a_bit_rate: assert property (p_bit_rate)
    else $error("serial stream faster than the bit rate");
  property p_flash;
    $rose(fiber_error_indicator_n_o) |-> low_cnt_r >= FLASH_LEN + 1;
  endproperty
  a_flash: assert property (p_flash)
    else $error("error indicator flash too short");
  property p_tp_quiet;
    !tp_en_r |-> test_port_out_o == '0;
  endproperty
  a_tp_quiet: assert property (p_tp_quiet)
    else $error("test port active while disabled");
  property p_ready;
    psel_i && penable_i |-> pready_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("access phase without ready");
  property p_slverr;
    psel_i && penable_i && paddr_i[1:0] == 2'b00 |-> pslverr_o == (paddr_i > OFS_ERR_COUNT);
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("wrong bus error response");
  property p_unmapped_read;
    psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned data");
endmodule
bind fiber_to_copper_symbol_path symbol_path_asserts #(
  .FLASH_LEN(FLASH_LEN)
) symbol_path_asserts_i (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .test_port_enable_i(test_port_enable_i),
  .tx_nrzi_o(tx_nrzi_o),
  .tx_mlt3_o(tx_mlt3_o),
  .fiber_error_indicator_n_o(fiber_error_indicator_n_o),
  .test_port_out_o(test_port_out_o),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o)
);

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import symbol_path_pkg::*;
  localparam int FLASH_SIM = 16;
  logic clk, rst, f_sd, tp_en, tp_side, bypass, sd, load, nrzi;
  logic psel, penable, pwrite, pready, pslverr, e, tx_nrzi, ind_n, irq;
  logic [3:0] tpi;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] sym;
  logic [6:0] tpo;
  mlt3_t mlt3;
  int fails, comparisons, cyc, n;
  fiber_source fiber_source_i (.sys_clk_i(clk), .rst_i(rst), .sym_i(sym), .nrzi_o(nrzi),
    .load_o(load));
  fiber_to_copper_symbol_path #(.FLASH_LEN(FLASH_SIM)) fiber_to_copper_symbol_path_i (
    .sys_clk_i(clk), .rst_i(rst), .force_fiber_signal_detect_i(f_sd),
    .test_port_enable_i(tp_en), .test_port_side_select_i(tp_side),
    .scrambler_bypass_i(bypass), .fiber_rx_nrzi_i(nrzi), .fiber_signal_detect_i(sd),
    .tx_nrzi_o(tx_nrzi), .tx_mlt3_o(mlt3), .fiber_error_indicator_n_o(ind_n),
    .test_port_in_i(tpi), .test_port_out_o(tpo), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  // Answer is taken at the edge that samples pready high, before clear-on-read lands
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reset_with(input logic [3:0] straps, input logic sd_v);
    {f_sd, tp_en, tp_side, bypass} <= straps;
    sd <= sd_v;
    tpi <= 4'h0;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send(input logic [4:0] s, input int cnt);
    sym <= s;
    repeat (cnt) @(posedge clk iff load);
  endtask
  task automatic jk_data;
    send(SYM_J, 1);
    send(SYM_K, 1);
    send(5'h0E, 6);
  endtask
  task automatic t_quiet;
    reset_with(4'h9, 1'b0);
    apb(1'b0, OFS_STRAPS, 32'h0);
    chk("straps", q, 32'h9);
    jk_data();
    chk("test port off", 32'(tpo), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
  endtask
  task automatic t_fiber;
    reset_with(4'hF, 1'b0);
    apb(1'b0, OFS_STRAPS, 32'h0);
    chk("straps", q, 32'hF);
    jk_data();
    chk("fiber port", 32'(tpo), 32'h6E);
    send(5'h00, 1);
    sym <= 5'h0E;
    for (n = 0; n < 60 && ind_n !== 1'b0; n++) @(posedge clk);
    chk("indicator", 32'(ind_n), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", q & 32'h3, 32'h3);
    apb(1'b0, OFS_ERR_COUNT, 32'h0);
    chk("err count", q, 32'h1);
    apb(1'b0, OFS_ERR_COUNT, 32'h0);
    chk("err count cleared", q, 32'h0);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, OFS_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'(irq), 32'h1);
    apb(1'b1, OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'(irq), 32'h0);
    send(SYM_IDLE, 3);
    chk("align dropped", 32'(tpo[6]), 32'h0);
  endtask
  task automatic t_copper(input logic bp);
    int hits;
    int tog;
    int rails;
    logic p;
    mlt3_t pm;
    reset_with({3'b110, bp}, 1'b0);
    jk_data();
    hits = int'(tpo[5:1] == 5'h0E);
    send(5'h0E, 1);
    hits += int'(tpo[5:1] == 5'h0E);
    chk("plain symbol", 32'(hits == 2), 32'(bp));
    if (bp) begin
      tog = 0;
      rails = 0;
      p = tx_nrzi;
      pm = mlt3;
      repeat (20) begin
        @(posedge clk);
        tog += int'(tx_nrzi !== p);
        rails += int'(pm == '0 && mlt3 != '0);
        p = tx_nrzi;
        pm = mlt3;
      end
      chk("serial ones", tog, 32'h6);
      chk("rail events", rails, 32'h3);
    end
  endtask
  task automatic t_nolink;
    reset_with(4'h5, 1'b0);
    send(5'h0E, 6);
    chk("idle", 32'(tpo[5:1]), 32'(SYM_IDLE));
    apb(1'b1, OFS_CTRL, 32'h1);
    send(5'h0E, 6);
    chk("halt", 32'(tpo[5:1]), 32'(SYM_HALT));
    sd <= 1'b1;
    jk_data();
    chk("linked", 32'(tpo[5:1]), 32'h0E);
    tpi <= 4'h3;
    send(5'h0E, 6);
    chk("forced halt", 32'(tpo[6:1]), 32'({1'b1, SYM_HALT}));
  endtask
  initial begin
    rst = 1'b1;
    {f_sd, tp_en, tp_side, bypass, sd, psel, penable, pwrite} = 8'h00;
    tpi = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sym = SYM_IDLE;
    @(posedge clk);
    t_quiet();
    t_fiber();
    t_copper(1'b1);
    t_copper(1'b0);
    t_nolink();
    report_and_stop();
  end
endmodule
